/* hw/ebg_gen.sv */
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ebg_params.svh"
module ebg_gen #(
	parameter int MS_CYC = `EBG_MS_NS / `EBG_CLK_NS,
	parameter int LINE_MBPS = 100000
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic [9:0] if_gbps,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [15:0] tx_len,
	output logic tx_burst,
	input wire logic rx_valid,
	input wire logic [47:0] rx_mac,
	input wire logic [31:0] rx_ip,
	input wire logic [11:0] rx_vlan,
	input wire logic [15:0] rx_port,
	input wire logic [15:0] rx_err_bits,
	input wire logic rx_lost,
	input wire logic [15:0] rx_lost_bits,
	output logic cap_valid,
	input wire logic ber_alarm_in,
	output logic ber_alarm,
	input wire logic fls_in,
	input wire logic fail_in,
	output logic summ_fail
);
	logic ack_q, req, wr, rd;
	logic [31:0] ctrl_q, mode_q, dur_q, lds_q, lde_q, ldst_q;
	logic [31:0] stdur_q, sz_q, szst_q, prof_q, macl_q, mach_q;
	logic [31:0] ip_q, vlp_q, perr_q, sfrm_q, tfrm_q;
	logic [31:0] rd_d;
	logic run_q, run_p, slow_ok, go;
	logic act_q, send, done;
	logic [9:0] msc_q;
	logic [31:0] mcnt_q;
	logic ms_t, s_t;
	logic [31:0] dsec_q, rstp_q, sstp_q;
	logic [31:0] cur_q, tgt, nld, ld, full;
	logic dir_q;
	logic [15:0] cs_q, lfsr_q, rng, rsz;
	logic [16:0] nsz;
	logic [47:0] cred_q, thr;
	logic hit;
	ebg_pkg::ebg_dur_t dm;
	ebg_pkg::ebg_sz_t sm;
	ebg_pkg::ebg_unit_t lu;
	ebg_pkg::ebg_ramp_t rm;
	ebg_pkg::ebg_prof_t pm;

	function automatic logic [15:0] enc_mbps(input logic [1:0] p,
		input logic [2:0] e);
		logic [15:0] r;
		r = 16'h0001;
		if (p == ebg_pkg::PR_VIDEO) begin
			unique case (e)
				3'h0: r = 16'h0002;
				3'h1: r = 16'h0004;
				3'h2: r = 16'h0008;
				default: r = 16'h0013;
			endcase
		end
		return r;
	endfunction

	function automatic logic [31:0] step_to(input logic [31:0] c,
		input logic [31:0] t, input logic [31:0] s);
		logic [32:0] u;
		u = {1'b0, c} + {1'b0, s};
		if (c < t)
			step_to = (u >= {1'b0, t}) ? t : u[31:0];
		else
			step_to = (c - t <= s) ? t : c - s;
	endfunction

	assign dm = ebg_pkg::ebg_dur_t'(mode_q[1:0]);
	assign sm = ebg_pkg::ebg_sz_t'(mode_q[3:2]);
	assign lu = ebg_pkg::ebg_unit_t'(mode_q[5:4]);
	assign rm = ebg_pkg::ebg_ramp_t'(mode_q[7:6]);
	assign pm = ebg_pkg::ebg_prof_t'(prof_q[29:28]);

	// avalon slave, one wait state
	assign req = read | write;
	assign waitrequest = req & ~ack_q;
	assign wr = write & ack_q;
	assign rd = read & ~ack_q;
	assign go = wr & (address == `EBG_A_CTRL) & writedata[`EBG_C_GO];

	always_ff @(posedge sys_clk) begin
		if (rst)
			ack_q <= 1'b0;
		else
			ack_q <= req & ~ack_q;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl_q <= `EBG_RST_CTRL;
			mode_q <= 32'h0;
			dur_q <= 32'h0;
			lds_q <= `EBG_RST_LD;
			lde_q <= `EBG_RST_LD;
			ldst_q <= 32'h1;
			stdur_q <= 32'h1;
			sz_q <= `EBG_RST_SZ;
			szst_q <= 32'h00010001;
			prof_q <= 32'h00000001;
			macl_q <= 32'h0;
			mach_q <= 32'h0;
			ip_q <= 32'h0;
			vlp_q <= 32'h0;
		end else if (wr) begin
			unique case (address)
				`EBG_A_CTRL: ctrl_q <= writedata & ~32'h2;
				`EBG_A_MODE: mode_q <= writedata;
				`EBG_A_DUR: dur_q <= writedata;
				`EBG_A_LDS: lds_q <= writedata;
				`EBG_A_LDE: lde_q <= writedata;
				`EBG_A_LDSTEP: ldst_q <= writedata;
				`EBG_A_STDUR: stdur_q <= writedata;
				`EBG_A_SZ: sz_q <= writedata;
				`EBG_A_SZSTEP: szst_q <= writedata;
				`EBG_A_PROF: prof_q <= writedata;
				`EBG_A_MACL: macl_q <= writedata;
				`EBG_A_MACH: mach_q <= {16'h0, writedata[15:0]};
				`EBG_A_IP: ip_q <= writedata;
				`EBG_A_VLP: vlp_q <= writedata;
				default: ;
			endcase
		end
	end

	always_comb begin
		unique case (address)
			`EBG_A_CTRL: rd_d = ctrl_q;
			`EBG_A_MODE: rd_d = mode_q;
			`EBG_A_DUR: rd_d = dur_q;
			`EBG_A_LDS: rd_d = lds_q;
			`EBG_A_LDE: rd_d = lde_q;
			`EBG_A_LDSTEP: rd_d = ldst_q;
			`EBG_A_STDUR: rd_d = stdur_q;
			`EBG_A_SZ: rd_d = sz_q;
			`EBG_A_SZSTEP: rd_d = szst_q;
			`EBG_A_PROF: rd_d = prof_q;
			`EBG_A_MACL: rd_d = macl_q;
			`EBG_A_MACH: rd_d = mach_q;
			`EBG_A_IP: rd_d = ip_q;
			`EBG_A_VLP: rd_d = vlp_q;
			`EBG_A_STAT: rd_d = {cs_q, 14'h0, dir_q, act_q};
			`EBG_A_PERR: rd_d = perr_q;
			`EBG_A_SFRM: rd_d = sfrm_q;
			`EBG_A_TFRM: rd_d = tfrm_q;
			default: rd_d = 32'h0;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			readdata <= 32'h0;
		else if (rd)
			readdata <= rd_d;
	end

	// test start edge and rate limits
	assign slow_ok = (if_gbps <= 10'(`EBG_MAX_GBPS));
	assign run_p = ctrl_q[`EBG_C_RUN] & ~run_q;

	always_ff @(posedge sys_clk) begin
		if (rst)
			run_q <= 1'b0;
		else
			run_q <= ctrl_q[`EBG_C_RUN];
	end

	// millisecond and second ticks
	assign ms_t = (mcnt_q == 32'(MS_CYC - 1));
	assign s_t = ms_t & (msc_q == 10'(`EBG_MS_PER_S - 1));

	always_ff @(posedge sys_clk) begin
		if (rst | ~act_q) begin
			mcnt_q <= 32'h0;
			msc_q <= 10'h0;
		end else begin
			mcnt_q <= ms_t ? 32'h0 : mcnt_q + 32'h1;
			if (ms_t)
				msc_q <= s_t ? 10'h0 : msc_q + 10'h1;
		end
	end

	// generator run control
	assign done = act_q &
		((dm == ebg_pkg::DUR_SEC && dsec_q >= dur_q) ||
		(dm == ebg_pkg::DUR_FRM && tfrm_q >= dur_q));

	always_ff @(posedge sys_clk) begin
		if (rst)
			act_q <= 1'b0;
		else if (ctrl_q[`EBG_C_OFF] | done)
			act_q <= 1'b0;
		else if (go | (run_p & ctrl_q[`EBG_C_AUTO] &
			dm == ebg_pkg::DUR_CONT))
			act_q <= 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (rst | go | run_p)
			dsec_q <= 32'h0;
		else if (s_t)
			dsec_q <= dsec_q + 32'h1;
	end

	// line load: profile or ramp
	assign ld = (pm != ebg_pkg::PR_DATA) ?
		32'(enc_mbps(pm, prof_q[18:16])) * 32'(prof_q[15:0]) :
		cur_q;
	assign tgt = dir_q ? lds_q : lde_q;
	assign nld = step_to(cur_q, tgt, ldst_q);

	always_ff @(posedge sys_clk) begin
		if (rst | ~act_q) begin
			cur_q <= lds_q;
			dir_q <= 1'b0;
			rstp_q <= 32'h0;
		end else if (ctrl_q[`EBG_C_RAMP] &
			((ctrl_q[`EBG_C_MSR] & slow_ok) ? ms_t : s_t)) begin
			if (rstp_q + 32'h1 >= stdur_q) begin
				rstp_q <= 32'h0;
				if (cur_q != tgt)
					cur_q <= nld;
				else begin
					unique case (rm)
						ebg_pkg::RM_REPEAT: cur_q <= lds_q;
						ebg_pkg::RM_INVERT: begin
							dir_q <= ~dir_q;
							cur_q <= step_to(cur_q,
								dir_q ? lde_q : lds_q, ldst_q);
						end
						default: ;
					endcase
				end
			end else
				rstp_q <= rstp_q + 32'h1;
		end
	end

	// frame size (headers+payload+fcs)
	assign rng = sz_q[31:16] - sz_q[15:0] + 16'h1;
	assign rsz = sz_q[15:0] + (lfsr_q % rng);
	assign nsz = {1'b0, cs_q} + {1'b0, szst_q[15:0]};

	always_ff @(posedge sys_clk) begin
		if (rst)
			lfsr_q <= 16'hace1;
		else if (send)
			lfsr_q <= {lfsr_q[14:0],
				lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
	end

	always_ff @(posedge sys_clk) begin
		if (rst | ~act_q) begin
			cs_q <= sz_q[15:0];
			sstp_q <= 32'h0;
		end else unique case (sm)
			ebg_pkg::SZ_STEP: if (s_t) begin
				if (sstp_q + 32'h1 >= {16'h0, szst_q[31:16]}) begin
					sstp_q <= 32'h0;
					if (cs_q == sz_q[31:16])
						cs_q <= sz_q[15:0];
					else if (nsz >= {1'b0, sz_q[31:16]})
						cs_q <= sz_q[31:16];
					else
						cs_q <= nsz[15:0];
				end else
					sstp_q <= sstp_q + 32'h1;
			end
			ebg_pkg::SZ_RAND: if (send)
				cs_q <= rsz;
			default: cs_q <= sz_q[15:0];
		endcase
	end

	// credit pacing keeps average load
	always_comb begin
		unique case (lu)
			ebg_pkg::LU_IFG: begin
				full = 32'h1;
				thr = 48'(cs_q) + 48'(`EBG_PRE) + 48'(cur_q);
			end
			ebg_pkg::LU_MBPS: begin
				full = 32'(LINE_MBPS);
				thr = (48'(cs_q) + 48'(`EBG_OVH)) * 48'(full);
			end
			default: begin
				full = 32'(`EBG_PCT_FULL);
				thr = (48'(cs_q) + 48'(`EBG_OVH)) * 48'(full);
			end
		endcase
		if (pm != ebg_pkg::PR_DATA)
			thr = (48'(cs_q) + 48'(`EBG_OVH)) * 48'(LINE_MBPS);
	end

	assign hit = (cred_q >= thr);
	assign tx_valid = act_q & hit & ~ctrl_q[`EBG_C_OFF];
	assign send = tx_valid & tx_ready;
	assign tx_len = cs_q;
	assign tx_burst = act_q & ctrl_q[`EBG_C_BURST] & slow_ok;

	always_ff @(posedge sys_clk) begin
		if (rst | ~act_q)
			cred_q <= 48'h0;
		else if (send)
			cred_q <= cred_q - thr;
		else if (~hit)
			cred_q <= cred_q + ((lu == ebg_pkg::LU_IFG &&
				pm == ebg_pkg::PR_DATA) ? 48'h1 : 48'(ld));
	end

	always_ff @(posedge sys_clk) begin
		if (rst | go | run_p)
			tfrm_q <= 32'h0;
		else if (send)
			tfrm_q <= tfrm_q + 32'h1;
	end

	// receive side
	always_ff @(posedge sys_clk) begin
		if (rst | run_p)
			perr_q <= 32'h0;
		else
			perr_q <= perr_q + (rx_valid ? 32'(rx_err_bits) : 32'h0) +
				((rx_lost & ctrl_q[`EBG_C_LOST]) ?
				32'(rx_lost_bits) : 32'h0);
	end

	always_ff @(posedge sys_clk) begin
		if (rst | run_p)
			sfrm_q <= 32'h0;
		else if (rx_valid & (~ctrl_q[`EBG_C_FILT] |
			({mach_q[15:0], macl_q} == rx_mac && ip_q == rx_ip &&
			vlp_q[27:16] == rx_vlan && vlp_q[15:0] == rx_port)))
			sfrm_q <= sfrm_q + 32'h1;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cap_valid <= 1'b0;
			ber_alarm <= 1'b0;
			summ_fail <= 1'b0;
		end else begin
			cap_valid <= rx_valid;
			ber_alarm <= ber_alarm_in &
				(~ctrl_q[`EBG_C_GATE] | ctrl_q[`EBG_C_RUN]);
			summ_fail <= fail_in |
				(fls_in & ~ctrl_q[`EBG_C_IGN]);
		end
	end

	// checks
	wait_one_a: assert property (@(posedge sys_clk) disable iff (rst)
		req & waitrequest |=> ~waitrequest)
		else $error("waitrequest held too long");
	lost_cnt_a: assert property (@(posedge sys_clk) disable iff (rst)
		rx_lost & ctrl_q[`EBG_C_LOST] & ~run_p & ~rx_valid |=>
		perr_q == $past(perr_q) + 32'($past(rx_lost_bits)))
		else $error("lost bits not counted");
	filt_a: assert property (@(posedge sys_clk) disable iff (rst)
		rx_valid & ctrl_q[`EBG_C_FILT] & ~run_p & rx_ip != ip_q |=>
		$stable(sfrm_q))
		else $error("unmatched frame counted");
	cap_a: assert property (@(posedge sys_clk) disable iff (rst)
		rx_valid |=> cap_valid)
		else $error("capture missed frame");
	gate_a: assert property (@(posedge sys_clk) disable iff (rst)
		ctrl_q[`EBG_C_GATE] & ~ctrl_q[`EBG_C_RUN] |=> ~ber_alarm)
		else $error("alarm outside measurement");
	fls_a: assert property (@(posedge sys_clk) disable iff (rst)
		ctrl_q[`EBG_C_IGN] & ~fail_in |=> ~summ_fail)
		else $error("loss seconds judged");
	off_a: assert property (@(posedge sys_clk) disable iff (rst)
		ctrl_q[`EBG_C_OFF] |-> ~tx_valid ##1 ~act_q)
		else $error("stream off ignored");
	auto_a: assert property (@(posedge sys_clk) disable iff (rst)
		run_p & ctrl_q[`EBG_C_AUTO] & dm == ebg_pkg::DUR_CONT &
		~ctrl_q[`EBG_C_OFF] |=> act_q)
		else $error("auto start failed");
	frm_a: assert property (@(posedge sys_clk) disable iff (rst)
		act_q & dm == ebg_pkg::DUR_FRM & tfrm_q >= dur_q |=> ~act_q)
		else $error("frame count overrun");
	const_a: assert property (@(posedge sys_clk) disable iff (rst)
		act_q & sm == ebg_pkg::SZ_CONST & $stable(sz_q) |=>
		tx_len == $past(sz_q[15:0]))
		else $error("constant size wrong");
	burst_a: assert property (@(posedge sys_clk) disable iff (rst)
		~slow_ok |-> ~tx_burst)
		else $error("burst above rate limit");
	clamp_a: assert property (@(posedge sys_clk) disable iff (rst)
		act_q & ~dir_q & lds_q <= lde_q & $stable(lde_q) |->
		cur_q <= lde_q)
		else $error("ramp passed end");
	send_c: cover property (@(posedge sys_clk) send);
	ramp_c: cover property (@(posedge sys_clk) act_q & dir_q);
	lost_c: cover property (@(posedge sys_clk)
		rx_lost & ctrl_q[`EBG_C_LOST]);
endmodule
`default_nettype wire

/* hw/ebg_params.svh */
`ifndef EBG_PARAMS_SVH
`define EBG_PARAMS_SVH
`define EBG_A_CTRL 8'h00
`define EBG_A_MODE 8'h04
`define EBG_A_DUR 8'h08
`define EBG_A_LDS 8'h0c
`define EBG_A_LDE 8'h10
`define EBG_A_LDSTEP 8'h14
`define EBG_A_STDUR 8'h18
`define EBG_A_SZ 8'h1c
`define EBG_A_SZSTEP 8'h20
`define EBG_A_PROF 8'h24
`define EBG_A_MACL 8'h28
`define EBG_A_MACH 8'h2c
`define EBG_A_IP 8'h30
`define EBG_A_VLP 8'h34
`define EBG_A_STAT 8'h38
`define EBG_A_PERR 8'h3c
`define EBG_A_SFRM 8'h40
`define EBG_A_TFRM 8'h44
`define EBG_C_RUN 0
`define EBG_C_GO 1
`define EBG_C_OFF 2
`define EBG_C_LOST 3
`define EBG_C_FILT 4
`define EBG_C_GATE 5
`define EBG_C_IGN 6
`define EBG_C_AUTO 7
`define EBG_C_BURST 8
`define EBG_C_RAMP 9
`define EBG_C_MSR 10
`define EBG_RST_CTRL 32'h00000000
`define EBG_RST_SZ 32'h05ee0040
`define EBG_RST_LD 32'h00000064
`define EBG_CLK_NS 10
`define EBG_MS_NS 1000000
`define EBG_MS_PER_S 1000
`define EBG_PCT_FULL 100
`define EBG_OVH 20
`define EBG_PRE 8
`define EBG_MAX_GBPS 100
`endif

/* hw/ebg_pkg.sv */
package ebg_pkg;
	typedef enum logic [1:0] {
		DUR_CONT = 2'b00,
		DUR_SEC = 2'b01,
		DUR_FRM = 2'b10
	} ebg_dur_t;
	typedef enum logic [1:0] {
		SZ_CONST = 2'b00,
		SZ_STEP = 2'b01,
		SZ_RAND = 2'b10
	} ebg_sz_t;
	typedef enum logic [1:0] {
		LU_PCT = 2'b00,
		LU_MBPS = 2'b01,
		LU_IFG = 2'b10
	} ebg_unit_t;
	typedef enum logic [1:0] {
		RM_KEEP = 2'b00,
		RM_REPEAT = 2'b01,
		RM_INVERT = 2'b10
	} ebg_ramp_t;
	typedef enum logic [1:0] {
		PR_DATA = 2'b00,
		PR_VIDEO = 2'b01,
		PR_VOICE = 2'b10
	} ebg_prof_t;
endpackage

/* tb/ebg_link.sv */
`timescale 1ns/1ps
`default_nettype none
module ebg_link (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clr,
	input wire logic slow,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [15:0] tx_len,
	output var int n_frm,
	output logic [15:0] len_lo,
	output logic [15:0] len_hi
);
	// sink stalls at random when slow
	always_ff @(posedge sys_clk) begin
		tx_ready <= slow ? 1'($urandom % 2) : 1'b1;
	end
	// frame count and size range seen
	always_ff @(posedge sys_clk) begin
		if (rst || clr) begin
			n_frm <= 0;
			len_lo <= 16'hffff;
			len_hi <= 16'h0000;
		end else if (tx_valid && tx_ready) begin
			n_frm <= n_frm + 1;
			if (tx_len < len_lo)
				len_lo <= tx_len;
			if (tx_len > len_hi)
				len_hi <= tx_len;
		end
	end
endmodule
`default_nettype wire

/* tb/tb_ethernet_bert_traffic_generator.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ebg_params.svh"
module tb_ethernet_bert_traffic_generator;
	localparam logic [47:0] MAC_C = 48'h02a1b2c3d4e5;
	localparam logic [31:0] IP_C = 32'hc0a80a07;
	localparam logic [11:0] VL_C = 12'h0a5;
	localparam logic [15:0] PT_C = 16'h1f90;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] address = 8'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata, rd_v;
	logic waitrequest, tx_valid, tx_ready, tx_burst;
	logic cap_valid, ber_alarm, summ_fail;
	logic [9:0] if_gbps = 10'h064;
	logic [15:0] tx_len, len_lo, len_hi, eb, lb, s_lo, s_hi;
	logic [31:0] rx_ip = IP_C;
	logic [11:0] rx_vlan = VL_C;
	logic rx_valid = 1'b0;
	logic rx_lost = 1'b0;
	logic [47:0] rx_mac = 48'h0;
	logic [15:0] rx_port = 16'h0;
	logic [15:0] rx_err_bits = 16'h0;
	logic [15:0] rx_lost_bits = 16'h0;
	logic ber_alarm_in = 1'b0;
	logic fls_in = 1'b0;
	logic fail_in = 1'b0;
	logic clr = 1'b0;
	logic slow = 1'b0;
	int n_frm, err_count, check_count, cap_n, c0;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];

	always #5 sys_clk = ~sys_clk;

	ebg_gen #(.MS_CYC(4)) DUT (.sys_clk(sys_clk), .rst(rst),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .if_gbps(if_gbps),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_len(tx_len),
		.tx_burst(tx_burst), .rx_valid(rx_valid), .rx_mac(rx_mac),
		.rx_ip(rx_ip), .rx_vlan(rx_vlan), .rx_port(rx_port),
		.rx_err_bits(rx_err_bits), .rx_lost(rx_lost),
		.rx_lost_bits(rx_lost_bits), .cap_valid(cap_valid),
		.ber_alarm_in(ber_alarm_in), .ber_alarm(ber_alarm),
		.fls_in(fls_in), .fail_in(fail_in), .summ_fail(summ_fail));
	ebg_link LNK (.sys_clk(sys_clk), .rst(rst), .clr(clr), .slow(slow),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_len(tx_len),
		.n_frm(n_frm), .len_lo(len_lo), .len_hi(len_hi));

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic bus(input logic rw, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		address <= a;
		writedata <= d;
		read <= rw;
		write <= !rw;
		do begin
			@(posedge sys_clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 100);
		if (n >= 100) begin
			err_count++;
			final_report();
		end
		rd_v = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b0, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		bus(1'b1, a, 32'h0);
	endtask
	task automatic wcyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic rxf(input logic [47:0] m, input logic [15:0] p,
		input logic [15:0] e, input logic lost);
		@(posedge sys_clk);
		rx_mac <= m;
		rx_port <= p;
		rx_err_bits <= e;
		rx_lost_bits <= e;
		rx_valid <= !lost;
		rx_lost <= lost;
		@(posedge sys_clk);
		rx_valid <= 1'b0;
		rx_lost <= 1'b0;
		rx_mac <= ~m;
		rx_port <= ~p;
		rx_err_bits <= ~e;
		rx_lost_bits <= ~e;
	endtask
	task automatic go(input logic [31:0] mode, input logic [31:0] dur);
		int n;
		wr(`EBG_A_CTRL, 32'h0);
		wr(`EBG_A_MODE, mode);
		wr(`EBG_A_DUR, dur);
		clr <= 1'b1;
		@(posedge sys_clk);
		clr <= 1'b0;
		wr(`EBG_A_CTRL, 32'h2);
		n = 0;
		do begin
			rd(`EBG_A_STAT, 32'h0, 32'h0);
			n++;
		end while (rd_v[0] !== 1'b0 && n < 8000);
		if (n >= 8000) begin
			err_count++;
			final_report();
		end
	endtask

	// read answers, capture pulses
	always @(posedge sys_clk) begin
		logic [31:0] e, m;
		if (read && waitrequest === 1'b0 && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			if (m != 32'h0)
				check("readdata", readdata & m, e & m);
		end
		if (cap_valid === 1'b1)
			cap_n++;
	end

	initial begin
		void'($urandom(32'h91e5));
		wcyc(5);
		rst <= 1'b0;
		rd(`EBG_A_SZ, `EBG_RST_SZ, '1);
		rd(`EBG_A_CTRL, `EBG_RST_CTRL, '1);
		wr(8'h80, 32'hffffffff);
		rd(8'h80, 32'h0, '1);
		eb = 16'($urandom % 1000);
		lb = 16'($urandom % 1000);
		wr(`EBG_A_CTRL, 32'h9);
		rxf(MAC_C, PT_C, eb, 1'b0);
		rxf(MAC_C, PT_C, lb, 1'b1);
		rd(`EBG_A_PERR, 32'(eb + lb), '1);
		wr(`EBG_A_CTRL, 32'h1);
		rxf(MAC_C, PT_C, lb, 1'b1);
		rd(`EBG_A_PERR, 32'(eb + lb), '1);
		wr(`EBG_A_MACL, MAC_C[31:0]);
		wr(`EBG_A_MACH, {16'h0, MAC_C[47:32]});
		wr(`EBG_A_IP, IP_C);
		wr(`EBG_A_VLP, {4'h0, VL_C, PT_C});
		wr(`EBG_A_CTRL, 32'h0);
		wr(`EBG_A_CTRL, 32'h11);
		c0 = cap_n;
		rxf(MAC_C, PT_C, 16'h0, 1'b0);
		rxf(MAC_C, ~PT_C, 16'h0, 1'b0);
		rxf(~MAC_C, PT_C, 16'h0, 1'b0);
		rxf(MAC_C, PT_C, 16'h0, 1'b0);
		rx_ip <= ~IP_C;
		rxf(MAC_C, PT_C, 16'h0, 1'b0);
		rx_ip <= IP_C;
		rx_vlan <= ~VL_C;
		rxf(MAC_C, PT_C, 16'h0, 1'b0);
		rx_vlan <= VL_C;
		rd(`EBG_A_SFRM, 32'h2, '1);
		check("cap_count", 32'(cap_n - c0), 32'h6);
		ber_alarm_in <= 1'b1;
		fls_in <= 1'b1;
		wr(`EBG_A_CTRL, 32'h60);
		wcyc(2);
		check("ber_alarm", 32'(ber_alarm), 32'h0);
		check("summ_fail", 32'(summ_fail), 32'h0);
		wr(`EBG_A_CTRL, 32'h21);
		wcyc(2);
		check("ber_alarm", 32'(ber_alarm), 32'h1);
		check("summ_fail", 32'(summ_fail), 32'h1);
		fail_in <= 1'b1;
		wr(`EBG_A_CTRL, 32'h60);
		wcyc(2);
		check("summ_fail", 32'(summ_fail), 32'h1);
		fail_in <= 1'b0;
		s_lo = 16'h0040 + 16'($urandom % 64);
		s_hi = s_lo + 16'h0028;
		wr(`EBG_A_SZ, {s_hi, s_lo});
		slow <= 1'b1;
		go(32'h02, 32'h5);
		check("frames", 32'(n_frm), 32'h5);
		check("len_lo", 32'(len_lo), 32'(s_lo));
		check("len_hi", 32'(len_hi), 32'(s_lo));
		rd(`EBG_A_TFRM, 32'h5, '1);
		rd(`EBG_A_CTRL, 32'h0, 32'h2);
		go(32'h0a, 32'h14);
		check("frames", 32'(n_frm), 32'h14);
		check("rand_lo", 32'(len_lo >= s_lo), 32'h1);
		check("rand_hi", 32'(len_hi <= s_hi), 32'h1);
		go(32'h22, 32'h4);
		check("frames", 32'(n_frm), 32'h4);
		check("len_hi", 32'(len_hi), 32'(s_lo));
		wr(`EBG_A_SZSTEP, 32'h0001001e);
		go(32'h05, 32'h3);
		c0 = n_frm;
		wcyc(50);
		check("stopped", 32'(n_frm - c0), 32'h0);
		check("len_lo", 32'(len_lo), 32'(s_lo));
		check("len_hi", 32'(len_hi), 32'(s_hi));
		wr(`EBG_A_MODE, 32'h0);
		wr(`EBG_A_CTRL, 32'h81);
		rd(`EBG_A_STAT, 32'h1, 32'h1);
		wr(`EBG_A_CTRL, 32'h181);
		wcyc(1);
		check("tx_burst", 32'(tx_burst), 32'h1);
		if_gbps <= 10'h0c8;
		wcyc(2);
		check("tx_burst", 32'(tx_burst), 32'h0);
		wcyc(300);
		check("sending", 32'(n_frm > c0), 32'h1);
		wr(`EBG_A_CTRL, 32'h185);
		wcyc(2);
		c0 = n_frm;
		wcyc(50);
		check("tx_valid", 32'(tx_valid), 32'h0);
		check("off", 32'(n_frm - c0), 32'h0);
		wr(`EBG_A_CTRL, 32'h0);
		wr(`EBG_A_MODE, 32'h80);
		wr(`EBG_A_LDS, 32'ha);
		wr(`EBG_A_LDE, 32'h32);
		wr(`EBG_A_LDSTEP, 32'ha);
		wr(`EBG_A_STDUR, 32'h2);
		wr(`EBG_A_CTRL, 32'h681);
		wcyc(50);
		rd(`EBG_A_STAT, 32'h1, 32'h3);
		wr(`EBG_A_CTRL, 32'h0);
		if_gbps <= 10'h064;
		wr(`EBG_A_CTRL, 32'h681);
		wcyc(50);
		rd(`EBG_A_STAT, 32'h3, 32'h3);
		final_report();
	end
endmodule
`default_nettype wire
